// file: hw/pin_func_pkg.sv
package pin_func_pkg;
  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [11:0] ADDR_THRESHOLD = 12'h1F6;
  localparam logic [11:0] ADDR_PIN_CTRL = 12'h200;
  localparam logic [11:0] ADDR_PIN_STATUS = 12'h204;
  // Threshold register layout.
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_WMASK = 8'h3F;
  localparam int THRESHOLD_SEL_LO = 0;
  localparam int THRESHOLD_SEL_HI = 1;
  // Threshold codes.
  localparam logic [1:0] THR_HALF = 2'h0;
  localparam logic [1:0] THR_LOW = 2'h1;
  localparam logic [1:0] THR_HIGH = 2'h2;
  // Pin control register fields.
  localparam logic [31:0] PIN_CTRL_RESET = 32'h0000_0000;
  localparam int PC_DIR0 = 0;
  localparam int PC_DIR1 = 1;
  localparam int PC_CH_LSB = 2;
  localparam int PC_GRP_LSB = 5;
  localparam int PC_TIMER_A_LSB = 7;
  localparam int PC_TX_SEL = 10;
  localparam int PC_SMODE_LSB = 11;
  localparam int PC_OPEN_DRAIN = 14;
  localparam int PC_PULLUP = 15;
  localparam int PC_DRIVE_HIGH = 16;
  localparam int PC_DATA0 = 17;
  localparam int PC_DATA1 = 18;
  // Selector values.
  localparam logic [2:0] CH_SEL_PIN0 = 3'h7;
  localparam logic [2:0] CH_SEL_PIN1 = 3'h6;
  localparam logic [1:0] GRP_SEL_PORT0 = 2'h0;
  localparam logic [2:0] TIMER_A_ON_PIN0 = 3'h2;
  localparam logic [2:0] TIMER_A_ON_PIN1 = 3'h3;
  // Serial modes counted as active transmit modes.
  localparam logic [2:0] SMODE_SYNC = 3'h1;
  localparam logic [2:0] SMODE_ASYNC7 = 3'h4;
  localparam logic [2:0] SMODE_ASYNC8 = 3'h5;
  localparam logic [2:0] SMODE_ASYNC9 = 3'h6;
  // Pin function codes shown in the status register, then bus response codes.
  localparam logic [2:0] FN_GP_IN = 3'h0;
  localparam logic [2:0] FN_GP_OUT = 3'h1;
  localparam logic [2:0] FN_ANALOG = 3'h2;
  localparam logic [2:0] FN_SERIAL_TX = 3'h3;
  localparam logic [2:0] FN_TIMER_A = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pin_func_pkg

// file: hw/port0_low_pin_function_select.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
// Behaviour
// - Each two-bit threshold field picks 0.50 (00), 0.35 (01) or 0.70 (10) of supply; 11 is forbidden but is stored if written.
// - Pin 0 is analog channel 7 when direction is 0, channel 111, group 00 and timer A select is not 010b.
// - Pin 1 is analog channel 6 when direction 0, channel 110, group 00, tx select 0, timer A not 011b.
// - Timer A select 010b puts the timer A signal on pin 0, the timer deciding input or output.
// - Pin 1 drives serial 1 transmit data when tx select is 1 and the serial mode is active.
// - With open-drain select 1 the serial transmit on pin 1 is N-channel open drain.
// - Pins 0 and 1 used as inputs get the pull-up when the port 0 low pull-up bit is 1.
// - Pins 0 and 1 used as outputs get high drive when the port 0 low drive bit is 1.
module port0_low_pin_function_select (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial1_transmit,
  input wire logic timer_chan_a_signal,
  input wire logic timer_chan_a_output_mode,
  input wire logic pin0_in,
  input wire logic pin1_in,
  output logic pin0_out,
  output logic pin0_oe_n,
  output logic pin1_out,
  output logic pin1_oe_n,
  output logic [1:0] pin_pullup_en,
  output logic [1:0] pin_drive_high,
  output logic analog_input_ch7,
  output logic analog_input_ch6,
  output logic timer_chan_a_in,
  output logic [1:0] threshold_sel_lo_hi,
  output logic [1:0] pin_sample
);
  logic [7:0] port4_input_threshold_ctrl;
  logic [31:0] pin_ctrl;
  logic [11:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [2:0] sync0;
  logic [2:0] sync1;
  logic [2:0] fn0;
  logic [2:0] fn1;
  logic [2:0] next_fn0;
  logic [2:0] next_fn1;
  logic [2:0] channel_sel;
  logic [1:0] group_sel;
  logic [2:0] timer_a_sel;
  logic [2:0] serial_mode_field;
  logic serial_active;
  logic do_write;

  assign channel_sel = pin_ctrl[pin_func_pkg::PC_CH_LSB +: 3];
  assign group_sel = pin_ctrl[pin_func_pkg::PC_GRP_LSB +: 2];
  assign timer_a_sel = pin_ctrl[pin_func_pkg::PC_TIMER_A_LSB +: 3];
  assign serial_mode_field = pin_ctrl[pin_func_pkg::PC_SMODE_LSB +: 3];
  assign serial_active = (serial_mode_field == pin_func_pkg::SMODE_SYNC) ||
                         (serial_mode_field == pin_func_pkg::SMODE_ASYNC7) ||
                         (serial_mode_field == pin_func_pkg::SMODE_ASYNC8) ||
                         (serial_mode_field == pin_func_pkg::SMODE_ASYNC9);

  // Write channel: address and data are held independently, so either may come first.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pin_func_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr[11:2] == pin_func_pkg::ADDR_THRESHOLD[11:2] ||
          aw_addr[11:2] == pin_func_pkg::ADDR_PIN_CTRL[11:2]) begin
        s_axi_bresp <= pin_func_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= pin_func_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Threshold register sits in the low byte of its word.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      port4_input_threshold_ctrl <= pin_func_pkg::THRESHOLD_RESET;
    end else if (do_write && w_strb[0] &&
                 aw_addr[11:2] == pin_func_pkg::ADDR_THRESHOLD[11:2]) begin
      port4_input_threshold_ctrl <= w_data[7:0] & pin_func_pkg::THRESHOLD_WMASK;
    end
  end

  // Code 11 is forbidden; the pad receives whatever is stored, so the choice is software's.
  assign threshold_sel_lo_hi = {port4_input_threshold_ctrl[pin_func_pkg::THRESHOLD_SEL_HI],
                                port4_input_threshold_ctrl[pin_func_pkg::THRESHOLD_SEL_LO]};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_ctrl <= pin_func_pkg::PIN_CTRL_RESET;
    end else if (do_write && aw_addr[11:2] == pin_func_pkg::ADDR_PIN_CTRL[11:2]) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          pin_ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
        end
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pin_func_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= pin_func_pkg::RESP_OKAY;
      case (s_axi_araddr[11:2])
        pin_func_pkg::ADDR_THRESHOLD[11:2]: s_axi_rdata <= {24'h000000, port4_input_threshold_ctrl};
        pin_func_pkg::ADDR_PIN_CTRL[11:2]: s_axi_rdata <= pin_ctrl;
        pin_func_pkg::ADDR_PIN_STATUS[11:2]: s_axi_rdata <= {24'h000000, pin_sample, fn1, fn0};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= pin_func_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Function resolution, peripheral claims first.
  always_comb begin
    if (timer_a_sel == pin_func_pkg::TIMER_A_ON_PIN0) begin
      next_fn0 = pin_func_pkg::FN_TIMER_A;
    end else if (!pin_ctrl[pin_func_pkg::PC_DIR0] && channel_sel == pin_func_pkg::CH_SEL_PIN0 &&
                 group_sel == pin_func_pkg::GRP_SEL_PORT0) begin
      next_fn0 = pin_func_pkg::FN_ANALOG;
    end else if (pin_ctrl[pin_func_pkg::PC_DIR0]) begin
      next_fn0 = pin_func_pkg::FN_GP_OUT;
    end else begin
      next_fn0 = pin_func_pkg::FN_GP_IN;
    end
  end

  always_comb begin
    if (pin_ctrl[pin_func_pkg::PC_TX_SEL] && serial_active) begin
      next_fn1 = pin_func_pkg::FN_SERIAL_TX;
    end else if (!pin_ctrl[pin_func_pkg::PC_TX_SEL] &&
                 timer_a_sel == pin_func_pkg::TIMER_A_ON_PIN1) begin
      next_fn1 = pin_func_pkg::FN_TIMER_A;
    end else if (!pin_ctrl[pin_func_pkg::PC_DIR1] && !pin_ctrl[pin_func_pkg::PC_TX_SEL] &&
                 channel_sel == pin_func_pkg::CH_SEL_PIN1 &&
                 group_sel == pin_func_pkg::GRP_SEL_PORT0) begin
      next_fn1 = pin_func_pkg::FN_ANALOG;
    end else if (pin_ctrl[pin_func_pkg::PC_DIR1]) begin
      next_fn1 = pin_func_pkg::FN_GP_OUT;
    end else begin
      next_fn1 = pin_func_pkg::FN_GP_IN;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fn0 <= pin_func_pkg::FN_GP_IN;
      fn1 <= pin_func_pkg::FN_GP_IN;
    end else begin
      fn0 <= next_fn0;
      fn1 <= next_fn1;
    end
  end

  // Pad drive, registered so the pins never glitch on a register write.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin0_out <= 1'b0;
      pin0_oe_n <= 1'b1;
      pin1_out <= 1'b0;
      pin1_oe_n <= 1'b1;
    end else begin
      case (fn0)
        pin_func_pkg::FN_GP_OUT: begin
          pin0_out <= pin_ctrl[pin_func_pkg::PC_DATA0];
          pin0_oe_n <= 1'b0;
        end
        pin_func_pkg::FN_TIMER_A: begin
          pin0_out <= timer_chan_a_signal;
          pin0_oe_n <= !timer_chan_a_output_mode;
        end
        default: begin
          pin0_out <= 1'b0;
          pin0_oe_n <= 1'b1;
        end
      endcase
      case (fn1)
        pin_func_pkg::FN_GP_OUT: begin
          pin1_out <= pin_ctrl[pin_func_pkg::PC_DATA1];
          pin1_oe_n <= 1'b0;
        end
        pin_func_pkg::FN_TIMER_A: begin
          pin1_out <= timer_chan_a_signal;
          pin1_oe_n <= !timer_chan_a_output_mode;
        end
        pin_func_pkg::FN_SERIAL_TX: begin
          if (pin_ctrl[pin_func_pkg::PC_OPEN_DRAIN]) begin
            pin1_out <= 1'b0;
            pin1_oe_n <= serial1_transmit;
          end else begin
            pin1_out <= serial1_transmit;
            pin1_oe_n <= 1'b0;
          end
        end
        default: begin
          pin1_out <= 1'b0;
          pin1_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Pull-up only while not driving, high drive only while driving.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_pullup_en <= 2'h0;
      pin_drive_high <= 2'h0;
      analog_input_ch7 <= 1'b0;
      analog_input_ch6 <= 1'b0;
      timer_chan_a_in <= 1'b0;
    end else begin
      pin_pullup_en[0] <= pin_ctrl[pin_func_pkg::PC_PULLUP] && pin0_oe_n;
      pin_pullup_en[1] <= pin_ctrl[pin_func_pkg::PC_PULLUP] && pin1_oe_n;
      pin_drive_high[0] <= pin_ctrl[pin_func_pkg::PC_DRIVE_HIGH] && !pin0_oe_n;
      pin_drive_high[1] <= pin_ctrl[pin_func_pkg::PC_DRIVE_HIGH] && !pin1_oe_n;
      analog_input_ch7 <= fn0 == pin_func_pkg::FN_ANALOG;
      analog_input_ch6 <= fn1 == pin_func_pkg::FN_ANALOG;
      // The timer input is registered like every other data output, at the cost of one cycle.
      timer_chan_a_in <= (fn0 == pin_func_pkg::FN_TIMER_A) ? pin_sample[0] : pin_sample[1];
    end
  end

  // Pins are asynchronous; a level is accepted once the second and third stages agree.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync0 <= 3'h0;
      sync1 <= 3'h0;
      pin_sample <= 2'h0;
    end else begin
      sync0 <= {sync0[1:0], pin0_in};
      sync1 <= {sync1[1:0], pin1_in};
      if (sync0[1] == sync0[2]) begin
        pin_sample[0] <= sync0[2];
      end
      if (sync1[1] == sync1[2]) begin
        pin_sample[1] <= sync1[2];
      end
    end
  end

endmodule : port0_low_pin_function_select

// file: tb/pin_sel_asserts.sv
`timescale 1ns/10ps
module pin_sel_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin0_oe_n,
  input wire logic pin1_oe_n,
  input wire logic [1:0] pin_pullup_en,
  input wire logic [1:0] pin_drive_high,
  input wire logic analog_input_ch7,
  input wire logic analog_input_ch6,
  input wire logic [1:0] threshold_sel_lo_hi
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic both_wr;
  logic thr_wr;
  logic thr_rd;
  assign both_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign thr_wr = both_wr && s_axi_wstrb[0] &&
                  s_axi_awaddr[11:2] == pin_func_pkg::ADDR_THRESHOLD[11:2];
  assign thr_rd = s_axi_arvalid && s_axi_arready &&
                  s_axi_araddr[11:2] == pin_func_pkg::ADDR_THRESHOLD[11:2];
  a_thr_write_lands: assert property (thr_wr |=> ##1 threshold_sel_lo_hi == $past(s_axi_wdata[1:0], 2))
    else $error("threshold field missed a write");
  a_thr_top_zero: assert property (thr_rd |=> s_axi_rdata[7:6] == 2'h0)
    else $error("threshold top bits not zero");
  a_pullup_input_only: assert property (pin_pullup_en[0] |-> $past(pin0_oe_n))
    else $error("pull-up on a driven pin");
  a_drive_output_only: assert property (pin_drive_high[0] |-> !$past(pin0_oe_n))
    else $error("high drive on an undriven pin");
  a_ch7_undriven: assert property (analog_input_ch7 [*3] |-> pin0_oe_n)
    else $error("analog pin 0 driven");
  a_ch6_undriven: assert property (analog_input_ch6 [*3] |-> pin1_oe_n)
    else $error("analog pin 1 driven");
  a_write_answer: assert property (both_wr |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : pin_sel_asserts

// file: tb/port0_low_pin_function_select_tb_top.sv
`timescale 1ns/10ps
module port0_low_pin_function_select_tb_top;
  localparam logic [11:0] THR = pin_func_pkg::ADDR_THRESHOLD;
  localparam logic [11:0] CTL = pin_func_pkg::ADDR_PIN_CTRL;
  localparam logic [11:0] STS = pin_func_pkg::ADDR_PIN_STATUS;
  localparam logic [1:0] OK = pin_func_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pin_func_pkg::RESP_SLVERR;
  logic clk = 1'h0, reset_n = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, serial1_transmit = 1'h0;
  logic timer_chan_a_signal = 1'h0, timer_chan_a_output_mode = 1'h0;
  logic pin0_in = 1'h0, pin1_in = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pin0_out, pin0_oe_n, pin1_out, pin1_oe_n, analog_input_ch7, analog_input_ch6;
  logic timer_chan_a_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, pin_pullup_en, pin_drive_high;
  logic [1:0] threshold_sel_lo_hi, pin_sample;
  logic [7:0] pads;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  assign pads = {pin1_oe_n, pin0_oe_n, pin1_out, pin0_out, pin_pullup_en, pin_drive_high};
  always #2.5 clk = ~clk;
  port0_low_pin_function_select i_dut (.*);

  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // The whole sequence needs a few hundred cycles, so this ceiling only trips on a hang.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      $display("mismatch at %0t: timeout", $time);
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'h0;
    // One idle edge keeps the ready line from being lowered and raised in one step.
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask : rd

  task automatic set(input logic [31:0] v);
    wr(CTL, v, OK);
    repeat (4) @(posedge clk);
  endtask : set

  task automatic t_regs();
    logic [1:0] codes [3] = '{pin_func_pkg::THR_HALF, pin_func_pkg::THR_LOW, pin_func_pkg::THR_HIGH};
    rd(THR, 32'h0, OK);
    rd(CTL, pin_func_pkg::PIN_CTRL_RESET, OK);
    chk(32'(pads), 32'hC0);
    foreach (codes[i]) begin
      wr(THR, 32'(codes[i]), OK);
      chk(32'(threshold_sel_lo_hi), 32'(codes[i]));
      rd(THR, 32'(codes[i]), OK);
    end
    wr(THR, 32'hFF, OK);
    rd(THR, 32'h3F, OK);
    s_axi_wstrb <= 4'hE;
    wr(THR, 32'h1, OK);
    s_axi_wstrb <= 4'hF;
    rd(THR, 32'h3F, OK);
    wr(THR, 32'h0, OK);
    wr(12'h300, 32'h1, ERR);
    rd(12'h300, 32'h0, ERR);
  endtask : t_regs

  task automatic t_gpio();
    set(32'h30003);
    chk(32'(pads), 32'h13);
    rd(STS, 32'h9, OK);
    pin0_in <= 1'h1;
    set(32'h8000);
    chk(32'(pads), 32'hCC);
    chk(32'(pin_sample), 32'h1);
    rd(STS, 32'h40, OK);
    pin0_in <= 1'h0;
  endtask : t_gpio

  task automatic t_analog();
    set(32'h1C);
    chk(32'({analog_input_ch7, analog_input_ch6}), 32'h2);
    rd(STS, 32'h2, OK);
    timer_chan_a_output_mode <= 1'h1;
    timer_chan_a_signal <= 1'h1;
    set(32'h11C);
    chk(32'({analog_input_ch7, pin0_oe_n, pin0_out}), 32'h1);
    rd(STS, 32'h4, OK);
    timer_chan_a_output_mode <= 1'h0;
    repeat (4) @(posedge clk);
    chk(32'(pin0_oe_n), 32'h1);
    timer_chan_a_output_mode <= 1'h1;
    pin1_in <= 1'h1;
    set(32'h198);
    chk(32'({analog_input_ch6, pin1_oe_n, pin1_out, timer_chan_a_in}), 32'h3);
    timer_chan_a_output_mode <= 1'h0;
    pin1_in <= 1'h0;
    timer_chan_a_signal <= 1'h0;
    set(32'h18);
    chk(32'({analog_input_ch7, analog_input_ch6}), 32'h1);
    set(32'h418);
    chk(32'(analog_input_ch6), 32'h0);
  endtask : t_analog

  task automatic t_serial();
    logic [2:0] md [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
    serial1_transmit <= 1'h1;
    foreach (md[i]) begin
      set(32'h400 | (32'(md[i]) << 11));
      chk(32'({pin1_oe_n, pin1_out}), (i == 0) ? 32'h2 : 32'h1);
    end
    serial1_transmit <= 1'h0;
    set(32'h40C02);
    chk(32'({pin1_oe_n, pin1_out}), 32'h0);
    set(32'h4C00);
    chk(32'({pin1_oe_n, pin1_out}), 32'h0);
    serial1_transmit <= 1'h1;
    repeat (4) @(posedge clk);
    chk(32'({pin1_oe_n, pin1_out}), 32'h2);
  endtask : t_serial

  // Read answered while rready is still low: the data must wait for the master.
  task automatic t_late_read();
    wr(THR, 32'h2A, OK);
    s_axi_araddr <= THR;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    repeat (3) @(posedge clk);
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_rvalid);
    chk(s_axi_rdata, 32'h2A);
    chk(32'(s_axi_rresp), 32'(OK));
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask : t_late_read

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_gpio();
    t_analog();
    t_serial();
    t_late_read();
    stop_test();
  end
endmodule : port0_low_pin_function_select_tb_top

bind port0_low_pin_function_select pin_sel_asserts i_chk (.*);
